// ==== emc_ctrl.sv ====
// External memory interface control pins with AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module emc_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [31:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic ext_if_clk_in_i,
  input wire logic [1:0] clk_select_strap_i,
  input wire logic hold_req_in_i,
  input wire logic async_ready_in_i,
  output logic hold_ack_out_o,
  output logic bus_req_out_o,
  output logic full_clk_out_o,
  output logic div_clk_out_o,
  output logic read_strobe_n_o,
  output logic out_en_strobe_n_o,
  output logic write_strobe_n_o,
  output logic fifo_space_out_en_n_o,
  output logic periph_xfer_out_n_o,
  output logic sdram_clk_en_o,
  output logic bus_oe_o
);

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] ext_clk_q, strap_q0, strap_q1, hold_q, rdy_q;

  // Two flops per pin; only the second stage is read
  always_ff @(posedge core_clk_i) begin
    ext_clk_q <= {ext_clk_q[0], ext_if_clk_in_i};
    hold_q <= {hold_q[0], hold_req_in_i};
    rdy_q <= {rdy_q[0], async_ready_in_i};
    strap_q0 <= clk_select_strap_i;
    strap_q1 <= strap_q0;
  end

  wire logic hold_s = hold_q[1];
  wire logic rdy_s = rdy_q[1];

  ////////////////////////////////////////////////////////////////
  // Interface clock selection
  logic [1:0] clk_sel;
  logic strap_taken;

  // Strap caught once after reset release; reserved code falls back
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strap_taken <= 1'b0;
      clk_sel <= emc_pkg::CSEL_EXT;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      if (strap_q1 == emc_pkg::CSEL_DIV4 || strap_q1 == emc_pkg::CSEL_DIV6) begin
        clk_sel <= strap_q1;
      end else begin
        clk_sel <= emc_pkg::CSEL_EXT;
      end
    end
  end

  logic [2:0] cpu_cnt;
  logic if_lvl, if_lvl_d;

  // CPU dividers give a level; external clock is its synchronised level
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cpu_cnt <= 3'h0;
      if_lvl <= 1'b0;
      if_lvl_d <= 1'b0;
    end else begin
      if_lvl_d <= if_lvl;
      case (clk_sel)
        emc_pkg::CSEL_DIV4: begin
          cpu_cnt <= (cpu_cnt >= emc_pkg::D4_LAST) ? 3'h0 : cpu_cnt + 3'h1;
          if_lvl <= (cpu_cnt < emc_pkg::D4_HIGH);
        end
        emc_pkg::CSEL_DIV6: begin
          cpu_cnt <= (cpu_cnt >= emc_pkg::D6_LAST) ? 3'h0 : cpu_cnt + 3'h1;
          if_lvl <= (cpu_cnt < emc_pkg::D6_HIGH);
        end
        default: begin
          cpu_cnt <= 3'h0;
          if_lvl <= ext_clk_q[1];
        end
      endcase
    end
  end

  // One-cycle enable at each rising edge of the interface clock
  wire logic if_tick = if_lvl & ~if_lvl_d;

  ////////////////////////////////////////////////////////////////
  // Registers
  logic [5:0] ctrl;
  logic [4:0] cmd;
  logic pending;
  emc_pkg::emc_state_e state;

  // Output clocks; division counts interface ticks
  logic [1:0] div_cnt;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      div_cnt <= 2'h0;
      full_clk_out_o <= 1'b0;
      div_clk_out_o <= 1'b0;
    end else begin
      full_clk_out_o <= if_lvl_d;
      if (if_tick) begin
        div_cnt <= div_cnt + 2'h1;
      end
      case (ctrl[emc_pkg::CTRL_DIV_LO +: 2])
        emc_pkg::DIV_1: div_clk_out_o <= if_lvl_d;
        emc_pkg::DIV_2: div_clk_out_o <= div_cnt[0];
        default: div_clk_out_o <= div_cnt[1];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  logic aw_held, w_held;
  logic [3:0] aw_ofs;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire logic wr_go = aw_held & w_held & ~s_bvalid_o;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_ofs <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= emc_pkg::RESP_OK;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_held <= 1'b1;
        aw_ofs <= s_awaddr_i[3:0];
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_wdata_i;
        w_strb <= s_wstrb_i;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= (aw_ofs == emc_pkg::OFS_CTRL || aw_ofs == emc_pkg::OFS_CMD ||
                      aw_ofs == emc_pkg::OFS_STAT) ? emc_pkg::RESP_OK : emc_pkg::RESP_ERR;
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  // Ready only while no word is held, so one write is under way
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_awready_o <= 1'b0;
      s_wready_o <= 1'b0;
    end else begin
      s_awready_o <= ~aw_held & ~(s_awvalid_i & s_awready_o);
      s_wready_o <= ~w_held & ~(s_wvalid_i & s_wready_o);
    end
  end

  // Control register; a command written while busy is dropped
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= emc_pkg::CTRL_RST;
      cmd <= 5'h0;
    end else if (wr_go && w_strb[0]) begin
      if (aw_ofs == emc_pkg::OFS_CTRL) begin
        ctrl <= w_data[5:0];
      end
      if (aw_ofs == emc_pkg::OFS_CMD && !pending) begin
        cmd <= w_data[4:0];
      end
    end
  end

  wire logic cmd_go = wr_go & w_strb[0] & (aw_ofs == emc_pkg::OFS_CMD) & ~pending;

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel: answer one cycle after the address
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h0;
      s_rresp_o <= emc_pkg::RESP_OK;
    end else begin
      s_arready_o <= ~s_rvalid_o & ~(s_arvalid_i & s_arready_o);
      if (s_arvalid_i && s_arready_o) begin
        s_rvalid_o <= 1'b1;
        s_rresp_o <= emc_pkg::RESP_OK;
        s_rdata_o <= 32'h0;
        case (s_araddr_i[3:0])
          emc_pkg::OFS_CTRL: s_rdata_o[5:0] <= ctrl;
          emc_pkg::OFS_CMD: s_rdata_o[4:0] <= cmd;
          emc_pkg::OFS_STAT: begin
            s_rdata_o[emc_pkg::ST_BUSY] <= pending;
            s_rdata_o[emc_pkg::ST_HOLDA] <= hold_ack_out_o;
            s_rdata_o[emc_pkg::ST_RDY] <= rdy_s;
            s_rdata_o[emc_pkg::ST_CSEL_LO +: 2] <= clk_sel;
          end
          default: s_rresp_o <= emc_pkg::RESP_ERR;
        endcase
      end else if (s_rvalid_o && s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Hold arbitration and access sequencing, paced by the interface clock
  wire logic [1:0] mtype = cmd[emc_pkg::CMD_TYPE_LO +: 2];
  wire logic is_wr = cmd[emc_pkg::CMD_WR];
  wire logic rsel = ctrl[emc_pkg::CTRL_RSEL];

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pending <= 1'b0;
      hold_ack_out_o <= 1'b0;
      bus_req_out_o <= 1'b0;
      bus_oe_o <= 1'b1;
      state <= emc_pkg::ST_IDLE;
    end else begin
      if (cmd_go) begin
        pending <= 1'b1;
      end
      bus_req_out_o <= pending | cmd_go;
      bus_oe_o <= ~hold_ack_out_o;
      if (if_tick) begin
        case (state)
          emc_pkg::ST_IDLE: begin
            if (hold_s) begin
              hold_ack_out_o <= 1'b1;
            end else if (hold_ack_out_o) begin
              hold_ack_out_o <= 1'b0;
            end else if (pending) begin
              state <= emc_pkg::ST_PH1;
            end
          end
          emc_pkg::ST_PH1: begin
            state <= (mtype == emc_pkg::MT_ASYNC) ? emc_pkg::ST_WAIT : emc_pkg::ST_PH2;
          end
          emc_pkg::ST_WAIT: begin
            if (rdy_s) begin
              state <= emc_pkg::ST_IDLE;
              pending <= 1'b0;
            end
          end
          emc_pkg::ST_PH2: begin
            state <= emc_pkg::ST_IDLE;
            pending <= 1'b0;
          end
          default: state <= emc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shared strobe pins, active low, chosen by memory type
  logic rd_n, oe_n, we_n, f3_n;
  always_comb begin
    rd_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    f3_n = 1'b1;
    if (state != emc_pkg::ST_IDLE) begin
      case (mtype)
        emc_pkg::MT_ASYNC: begin
          rd_n = is_wr;
          oe_n = is_wr;
          we_n = ~is_wr;
        end
        emc_pkg::MT_SDRAM: begin
          oe_n = (state != emc_pkg::ST_PH1);
          rd_n = (state != emc_pkg::ST_PH2);
          we_n = ~(is_wr && state == emc_pkg::ST_PH2);
        end
        emc_pkg::MT_SYNC: begin
          // Address strobe marks only the first phase unless CTRL_RSEL is set; read enable spans both
          rd_n = rsel ? is_wr : (state != emc_pkg::ST_PH1);
          oe_n = is_wr;
          we_n = ~is_wr;
          f3_n = is_wr | ~cmd[emc_pkg::CMD_SP3];
        end
        default: begin
          rd_n = 1'b1;
        end
      endcase
    end
  end

  // Registered pins; clock enable drops for self-refresh or is a plain output
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      read_strobe_n_o <= 1'b1;
      out_en_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      fifo_space_out_en_n_o <= 1'b1;
      periph_xfer_out_n_o <= 1'b1;
      sdram_clk_en_o <= 1'b1;
    end else begin
      read_strobe_n_o <= rd_n;
      out_en_strobe_n_o <= oe_n;
      write_strobe_n_o <= we_n;
      fifo_space_out_en_n_o <= f3_n;
      periph_xfer_out_n_o <= ~(cmd[emc_pkg::CMD_PDT] && state != emc_pkg::ST_IDLE);
      if (ctrl[emc_pkg::CTRL_SDPRES]) begin
        sdram_clk_en_o <= ~ctrl[emc_pkg::CTRL_SREF];
      end else begin
        sdram_clk_en_o <= ctrl[emc_pkg::CTRL_GPO];
      end
    end
  end

endmodule // emc_ctrl
`default_nettype wire

// ==== emc_ctrl_asserts.sv ====
// Checker of the memory control pins
`timescale 1ns/1ps
`default_nettype none
module emc_ctrl_asserts (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hold_req_in_i,
  input wire logic hold_ack_out_o,
  input wire logic bus_req_out_o,
  input wire logic bus_oe_o,
  input wire logic read_strobe_n_o,
  input wire logic out_en_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic fifo_space_out_en_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // Grant steps: acknowledge rises, pins float on the next cycle
  sequence s_grant;
    $rose(hold_ack_out_o) ##1 !bus_oe_o;
  endsequence
  sequence s_idle_req;
    !bus_req_out_o && !hold_ack_out_o && $rose(hold_req_in_i);
  endsequence
  chk_grant_float: assert property ($rose(hold_ack_out_o) |-> s_grant)
    else $error("pins driven in hold");
  chk_grant_bound: assert property (s_idle_req |-> ##[1:60] hold_ack_out_o)
    else $error("hold never granted");
  chk_grant_cause: assert property ($rose(hold_ack_out_o) |-> $past(hold_req_in_i, 2))
    else $error("grant without request");
  chk_release_cause: assert property ($fell(hold_ack_out_o) |-> !$past(hold_req_in_i, 2))
    else $error("grant dropped early");
  // The host owns the bus, so neither the read nor the write strobe may move
  chk_hold_quiet: assert property (hold_ack_out_o |-> read_strobe_n_o && write_strobe_n_o)
    else $error("strobe in hold");
  chk_req_first: assert property ($fell(read_strobe_n_o) |-> $past(bus_req_out_o))
    else $error("access without request");
  chk_fifo_oe: assert property (!fifo_space_out_en_n_o |-> !out_en_strobe_n_o)
    else $error("fifo enable alone");
  chk_we_alone: assert property (!write_strobe_n_o |-> out_en_strobe_n_o)
    else $error("write with output enable");
endmodule // emc_ctrl_asserts
bind emc_ctrl emc_ctrl_asserts u_chk (.*);
`default_nettype wire

// ==== emc_ctrl_test.sv ====
// Bench for the memory control-pin block
`timescale 1ns/1ps
`default_nettype none
module emc_ctrl_test;
  typedef struct {logic [1:0] s; logic [1:0] d; int f; int v;} emc_row_s;
  typedef struct {logic [31:0] c; logic [4:0] m;} emc_acc_s;
  logic core_clk_i = '0, rst_n_i = '0, ext_if_clk_in_i = '0, hold_req_in_i = '0;
  logic s_awvalid_i = '0, s_wvalid_i = '0, s_bready_i = '0, s_arvalid_i = '0, s_rready_i = '0;
  logic [31:0] s_awaddr_i = '0, s_wdata_i = '0, s_araddr_i = '0, s_rdata_o, d;
  logic [3:0] s_wstrb_i = 4'hF;
  logic [1:0] clk_select_strap_i = '0, s_bresp_o, s_rresp_o, r;
  logic [4:0] lat = 5'h02;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, hold_ack_out_o;
  logic bus_req_out_o, full_clk_out_o, div_clk_out_o, read_strobe_n_o, out_en_strobe_n_o;
  logic write_strobe_n_o, fifo_space_out_en_n_o, periph_xfer_out_n_o, sdram_clk_en_o, bus_oe_o;
  wire logic async_ready_in_i;
  int mismatches = 0, samples_checked = 0, n[5], nf, nd, t;
  emc_row_s rows[4] = '{'{2'h0, 2'h0, 30, 30}, '{2'h1, 2'h1, 60, 30},
    '{2'h2, 2'h2, 40, 10}, '{2'h1, 2'h3, 60, 15}};
  emc_acc_s accs[8] = '{'{32'h00, 5'h03}, '{32'h04, 5'h04}, '{32'h01, 5'h03},
    '{32'h05, 5'h07}, '{32'h02, 5'h03}, '{32'h06, 5'h05}, '{32'h0A, 5'h0B}, '{32'h10, 5'h13}};
  emc_ctrl dut (.*);
  emc_mem_model mem (.clk_i(core_clk_i), .rd_n_i(read_strobe_n_o), .oe_n_i(out_en_strobe_n_o),
    .wr_n_i(write_strobe_n_o), .lat_i(lat), .rdy_o(async_ready_in_i));
  ////////////////////////////////////////
  // Core clock, and an interface clock offset so the edges never line up
  initial forever #12.5 core_clk_i = ~core_clk_i;
  initial begin
    #7;
    forever #100 ext_if_clk_in_i = ~ext_if_clk_in_i;
  end
  // Watchdog far beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk_i);
    mismatches++;
    summarize();
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] s);
    clk_select_strap_i <= s;
    rst_n_i <= 1'h0;
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    @(posedge core_clk_i);
  endtask
  // Bus tasks hold every valid until its own ready edge
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    s_awaddr_i <= {28'h0, a};
    s_wdata_i <= v;
    s_awvalid_i <= 1'h1;
    s_wvalid_i <= 1'h1;
    s_bready_i <= 1'h1;
    for (int k = 0; k < 40 && s_bvalid_o !== 1'h1; k++) begin
      @(posedge core_clk_i);
      if (s_awready_o) s_awvalid_i <= 1'h0;
      if (s_wready_o) s_wvalid_i <= 1'h0;
    end
    // A write that never gets its response counts as a mismatch
    if (s_bvalid_o !== 1'h1) begin
      mismatches++;
      $display("[ERR] t=%0t bvalid=%h exp=%h", $time, s_bvalid_o, 1'h1);
      s_awvalid_i <= 1'h0;
      s_wvalid_i <= 1'h0;
    end
    r = s_bresp_o;
    s_bready_i <= 1'h0;
    @(posedge core_clk_i);
  endtask
  task automatic axr(input logic [3:0] a);
    s_araddr_i <= {28'h0, a};
    s_arvalid_i <= 1'h1;
    s_rready_i <= 1'h1;
    for (int k = 0; k < 40 && s_rvalid_o !== 1'h1; k++) begin
      @(posedge core_clk_i);
      if (s_arready_o) s_arvalid_i <= 1'h0;
    end
    // A read that never gets its data counts as a mismatch
    if (s_rvalid_o !== 1'h1) begin
      mismatches++;
      $display("[ERR] t=%0t rvalid=%h exp=%h", $time, s_rvalid_o, 1'h1);
      s_arvalid_i <= 1'h0;
    end
    d = s_rdata_o;
    r = s_rresp_o;
    s_rready_i <= 1'h0;
    @(posedge core_clk_i);
  endtask
  task automatic meas;
    logic pf, pv;
    nf = 0;
    nd = 0;
    for (int k = 0; k < 240; k++) begin
      pf = full_clk_out_o;
      pv = div_clk_out_o;
      @(posedge core_clk_i);
      nf += full_clk_out_o & !pf;
      nd += div_clk_out_o & !pv;
    end
  endtask
  // Counts low cycles of each strobe until the request drops
  task automatic acc(input logic [31:0] c, input logic w);
    n = '{default: 0};
    if (w) axw(emc_pkg::OFS_CMD[3:0], c);
    for (int k = 0; k < 300; k++) begin
      @(posedge core_clk_i);
      n[0] += !read_strobe_n_o;
      n[1] += !out_en_strobe_n_o;
      n[2] += !write_strobe_n_o;
      n[3] += !fifo_space_out_en_n_o;
      n[4] += !periph_xfer_out_n_o;
      if (k > 4 && !bus_req_out_o) break;
    end
  endtask
  task automatic ck(input logic [31:0] c, input logic e);
    axw(emc_pkg::OFS_CTRL, c);
    repeat (2) @(posedge core_clk_i);
    chk(sdram_clk_en_o, e, e);
  endtask
  ////////////////////////////////////////
  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i].s);
      axw(emc_pkg::OFS_CTRL, {30'h0, rows[i].d} | 32'h8);
      axr(emc_pkg::OFS_STAT);
      chk(d[4:3], rows[i].s, rows[i].s);
      meas();
      chk(nf, rows[i].f - 2, rows[i].f + 2);
      chk(nd, rows[i].v - 2, rows[i].v + 2);
    end
    $display("clock table done");
    // Reserved strap code falls back to the external clock
    do_reset(2'h3);
    axr(emc_pkg::OFS_STAT);
    chk(d[4:3], emc_pkg::CSEL_EXT, emc_pkg::CSEL_EXT);
    do_reset(2'h1);
    d = {read_strobe_n_o, out_en_strobe_n_o, write_strobe_n_o, fifo_space_out_en_n_o,
      periph_xfer_out_n_o, sdram_clk_en_o, hold_ack_out_o, bus_req_out_o, bus_oe_o};
    chk(d, 32'h1F9, 32'h1F9);
    axr(emc_pkg::OFS_CTRL);
    chk(d, emc_pkg::CTRL_RST, emc_pkg::CTRL_RST);
    axr(4'hC);
    chk(r, emc_pkg::RESP_ERR, emc_pkg::RESP_ERR);
    axw(4'hC, 32'h0);
    chk(r, emc_pkg::RESP_ERR, emc_pkg::RESP_ERR);
    foreach (accs[i]) begin
      acc(accs[i].c, 1'h1);
      d = {n[4] != 0, n[3] != 0, n[2] != 0, n[1] != 0, n[0] != 0};
      chk(d, accs[i].m, accs[i].m);
    end
    $display("access table done");
    // Address strobe is one tick only unless CTRL_RSEL is set, read enable spans the access
    acc(32'h02, 1'h1);
    chk(n[0], 1, n[1] - 1);
    axw(emc_pkg::OFS_CTRL, 32'hC);
    acc(32'h02, 1'h1);
    chk(n[0], n[1], n[1]);
    lat <= 5'h14;
    acc(32'h0, 1'h1);
    chk(n[0], 20, 99);
    lat <= 5'h02;
    ck(32'h18, 1'h0);
    ck(32'h20, 1'h1);
    ck(32'h00, 1'h0);
    ck(32'h08, 1'h1);
    $display("strobe and clock-enable tests done");
    hold_req_in_i <= 1'h1;
    for (t = 0; t < 60 && hold_ack_out_o !== 1'h1; t++) @(posedge core_clk_i);
    chk(hold_ack_out_o, 1, 1);
    repeat (2) @(posedge core_clk_i);
    chk(bus_oe_o, 0, 0);
    acc(32'h0, 1'h1);
    chk(n[0] + n[2], 0, 0);
    chk(bus_req_out_o, 1, 1);
    hold_req_in_i <= 1'h0;
    acc(32'h0, 1'h0);
    chk(n[0], 1, 99);
    chk(hold_ack_out_o, 0, 0);
    $display("hold test done");
    summarize();
  end
endmodule // emc_ctrl_test
`default_nettype wire

// ==== emc_mem_model.sv ====
// Asynchronous memory that answers its strobes with a ready level
`timescale 1ns/1ps
`default_nettype none
module emc_mem_model (
  input wire logic clk_i,
  input wire logic rd_n_i,
  input wire logic oe_n_i,
  input wire logic wr_n_i,
  input wire logic [4:0] lat_i,
  output logic rdy_o
);
  logic [4:0] cnt = 5'h00;
  ////////////////////////////////////////
  // Count strobed cycles; a slow part just asks for a larger lat_i
  always @(posedge clk_i) begin
    if (rd_n_i && oe_n_i && wr_n_i) begin
      cnt <= 5'h00;
    end else if (cnt != 5'h1F) begin
      cnt <= cnt + 5'h01;
    end
  end
  // Ready falls as the access ends, so a stale ready never leaks
  assign rdy_o = (cnt >= lat_i);
endmodule // emc_mem_model
`default_nettype wire

// ==== emc_pkg.sv ====
// Constants shared by the external memory control-pin block
package emc_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  // Control register fields
  localparam int CTRL_DIV_LO = 0;
  localparam int CTRL_RSEL = 2;
  localparam int CTRL_SDPRES = 3;
  localparam int CTRL_SREF = 4;
  localparam int CTRL_GPO = 5;
  localparam logic [5:0] CTRL_RST = 6'h08;
  // Command register fields
  localparam int CMD_TYPE_LO = 0;
  localparam int CMD_WR = 2;
  localparam int CMD_SP3 = 3;
  localparam int CMD_PDT = 4;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_HOLDA = 1;
  localparam int ST_RDY = 2;
  localparam int ST_CSEL_LO = 3;
  // Memory types of an access
  localparam logic [1:0] MT_ASYNC = 2'h0;
  localparam logic [1:0] MT_SDRAM = 2'h1;
  localparam logic [1:0] MT_SYNC = 2'h2;
  // Interface clock select strap codes
  localparam logic [1:0] CSEL_EXT = 2'h0;
  localparam logic [1:0] CSEL_DIV4 = 2'h1;
  localparam logic [1:0] CSEL_DIV6 = 2'h2;
  // Divider of the second output clock
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  // CPU clock dividers: last count and high-phase length
  localparam logic [2:0] D4_LAST = 3'h3;
  localparam logic [2:0] D4_HIGH = 3'h2;
  localparam logic [2:0] D6_LAST = 3'h5;
  localparam logic [2:0] D6_HIGH = 3'h3;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Access sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_PH1, ST_PH2, ST_WAIT} emc_state_e;
endpackage : emc_pkg
